// file: verilog/i2cmt_pkg.sv
`default_nettype none
package i2cmt_pkg;
   // buffer geometry
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 8;
   // link timing: quarter of an scl period and idle time before a start
   localparam int LINK_PERIOD_PS = 12000;
   localparam int SCL_QTR_NS = 2500;
   localparam int BUS_FREE_NS = 4700;
   localparam int QTR_CYC = (SCL_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int BUS_FREE_CYC = (BUS_FREE_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int QCNT_W = 9;
   localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QTR_CYC - 1);
   localparam logic [QCNT_W-1:0] FREE_FULL = QCNT_W'(BUS_FREE_CYC);
   localparam logic [QCNT_W-1:0] Q_ONE = 9'h001;
   localparam logic [QCNT_W-1:0] Q_ZERO = 9'h000;
   // byte count and bit position constants
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ONE = 3'h1;
   localparam int MSB = 7;
   // quarter phases within one scl bit time
   localparam logic [1:0] PH0 = 2'h0;
   localparam logic [1:0] PH1 = 2'h1;
   localparam logic [1:0] PH2 = 2'h2;
   localparam logic [1:0] PH3 = 2'h3;
   // software clear strobes
   localparam int CLR_TX_INTERRUPT_FLAG = 0;
   localparam int CLR_COUNT_COMPLETE_FLAG = 1;
   localparam int CLR_NACK = 2;
   // positions in the two crossing vectors
   localparam int X_W = 4;
   localparam int L_SCL = 0;
   localparam int L_SDA = 1;
   localparam int L_REQ = 2;
   localparam int L_REL = 3;
   localparam int S_MID = 0;
   localparam int S_DONE = 1;
   localparam int S_ACKB = 2;
   localparam int S_FREE = 3;

   typedef enum logic [3:0] {
      CMD_START = 4'h1, CMD_RESTART = 4'h2, CMD_BYTE = 4'h4, CMD_STOP = 4'h8
   } i2cmt_cmd_e;
   typedef enum logic [2:0] {
      KIND_AHI = 3'h1, KIND_ALO = 3'h2, KIND_DATA = 3'h4
   } i2cmt_kind_e;
   typedef enum logic [6:0] {
      SQ_IDLE = 7'h01, SQ_START = 7'h02, SQ_BYTE = 7'h04, SQ_HOLD = 7'h08,
      SQ_LOWAIT = 7'h10, SQ_RSWAIT = 7'h20, SQ_STOP = 7'h40
   } i2cmt_seq_e;
   typedef enum logic [5:0] {
      EN_IDLE = 6'h01, EN_START = 6'h02, EN_BIT = 6'h04, EN_HOLD = 6'h08,
      EN_ACK = 6'h10, EN_STOP = 6'h20
   } i2cmt_eng_e;

   typedef struct packed {
      i2cmt_cmd_e kind;
      logic [BYTE_W-1:0] data;
   } i2cmt_cmd_s;
   typedef struct packed {
      logic abd;
      logic ten_bit;
      logic restart_enable;
   } i2cmt_cfg_s;
   typedef struct packed {
      logic start_bit;
      logic tx_interrupt_flag;
      logic master_data_request;
      logic count_complete_flag;
      logic tx_buffer_empty_flag;
      logic bus_free;
      logic nack;
      logic busy;
   } i2cmt_stat_s;

   // a crossed bit moves on once the second and third stages agree
   function automatic logic [X_W-1:0] sync_filt(input logic [X_W-1:0] s2,
                                                input logic [X_W-1:0] s3,
                                                input logic [X_W-1:0] f);
      sync_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
   endfunction
endpackage
`default_nettype wire

// file: verilog/i2cmt_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// depth must be a power of two: pointers wrap by overflow
module i2cmt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] C_ONE = (AW + 1)'(1);
   localparam logic [AW:0] C_ZERO = (AW + 1)'(0);
   localparam logic [AW:0] C_FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] P_ONE = AW'(1);
   localparam logic [AW-1:0] P_ZERO = AW'(0);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [AW:0] cnt_ff;
   logic [AW:0] nxt_cnt;
   logic full_n_ff;
   logic valid_ff;

   wire push = in_valid_in & full_n_ff;
   wire pop = valid_ff & out_ready_in;

   assign nxt_cnt = (push & ~pop) ? cnt_ff + C_ONE :
                    (~push & pop) ? cnt_ff - C_ONE : cnt_ff;
   assign in_ready_out = full_n_ff;
   assign out_valid_out = valid_ff;
   assign out_data_out = mem[rp_ff];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wp_ff] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wp_ff <= P_ZERO;
         rp_ff <= P_ZERO;
         cnt_ff <= C_ZERO;
         full_n_ff <= 1'h1;
         valid_ff <= 1'h0;
      end else begin
         wp_ff <= push ? wp_ff + P_ONE : wp_ff;
         rp_ff <= pop ? rp_ff + P_ONE : rp_ff;
         cnt_ff <= nxt_cnt;
         full_n_ff <= (nxt_cnt != C_FULL);
         valid_ff <= (nxt_cnt != C_ZERO);
      end
   end
endmodule // i2cmt_fifo
`default_nettype wire

// file: verilog/i2cmt_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2cmt_top (
   // system clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // link clock
   input wire logic link_clk_in,
   // bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // configuration
   input wire i2cmt_pkg::i2cmt_cfg_s cfg_in,
   input wire logic [7:0] address_buffer_high_in,
   input wire logic [7:0] address_buffer_low_in,
   // control strobes
   input wire logic start_set_in,
   input wire logic count_load_in,
   input wire logic [7:0] count_value_in,
   input wire logic [2:0] flag_clear_in,
   // transmit buffer write
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   // status
   output logic [7:0] byte_count_out,
   output i2cmt_pkg::i2cmt_stat_s status_out
);
   // ---------------- system domain ----------------
   i2cmt_pkg::i2cmt_seq_e st_ff, nxt_st;
   i2cmt_pkg::i2cmt_kind_e kind_ff, nxt_kind;
   i2cmt_pkg::i2cmt_cmd_s cmd_ff, nxt_cmd;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [7:0] addr_ff, nxt_addr;
   logic req_ff, nxt_req, rel_ff, nxt_rel;
   logic tx_interrupt_flag_ff, count_complete_flag_ff, nack_ff, mdr_ff, nxt_mdr, sb_ff, nxt_sb, busy_ff;
   logic set_tx_interrupt_flag, set_count_complete_flag, set_nack, pop;
   logic [i2cmt_pkg::X_W-1:0] ls1_ff, ls2_ff, ls3_ff, lsf_ff, lsp_ff;
   logic fifo_ov, fifo_empty_n;
   logic [7:0] fifo_od;
   // link domain flops seen from here only through ls1_ff
   logic mid_tgl_ff, done_tgl_ff, ack_ff, free_ff;

   i2cmt_fifo #(
      .WIDTH(i2cmt_pkg::BYTE_W),
      .DEPTH(i2cmt_pkg::FIFO_DEPTH)
   ) u_txbuf (
      .clk_in(mclk_in),
      .nrst_in(nrst_in),
      .in_valid_in(tx_valid_in),
      .in_data_in(tx_data_in),
      .in_ready_out(tx_ready_out),
      .out_valid_out(fifo_ov),
      .out_data_out(fifo_od),
      .out_ready_in(pop)
   );
   assign fifo_empty_n = fifo_ov;

   wire [i2cmt_pkg::X_W-1:0] l2s_raw = {free_ff, ack_ff, done_tgl_ff, mid_tgl_ff};
   wire mid_ev = lsf_ff[i2cmt_pkg::S_MID] ^ lsp_ff[i2cmt_pkg::S_MID];
   wire done_ev = lsf_ff[i2cmt_pkg::S_DONE] ^ lsp_ff[i2cmt_pkg::S_DONE];
   wire nacked = lsf_ff[i2cmt_pkg::S_ACKB];
   wire cnt_nz = (cnt_ff != i2cmt_pkg::CNT_ZERO);
   wire ten_hi = cfg_in.ten_bit & (kind_ff == i2cmt_pkg::KIND_AHI);
   // the start request only counts with the address buffers in use; with abd a buffered word starts
   wire go_start = cfg_in.abd ? fifo_ov : start_set_in;
   wire need_hold = cnt_nz & ~fifo_ov & ~ten_hi;
   wire [7:0] cnt_dec = cnt_ff - i2cmt_pkg::CNT_ONE;

   assign byte_count_out = cnt_ff;
   assign status_out = '{start_bit: sb_ff, tx_interrupt_flag: tx_interrupt_flag_ff, master_data_request: mdr_ff, count_complete_flag: count_complete_flag_ff,
                         tx_buffer_empty_flag: ~fifo_empty_n, bus_free: lsf_ff[i2cmt_pkg::S_FREE],
                         nack: nack_ff, busy: busy_ff};

   always_comb begin
      nxt_st = st_ff;
      nxt_kind = kind_ff;
      nxt_cmd = cmd_ff;
      nxt_cnt = cnt_ff;
      nxt_addr = addr_ff;
      nxt_req = req_ff;
      nxt_rel = rel_ff;
      nxt_mdr = mdr_ff;
      nxt_sb = sb_ff;
      set_tx_interrupt_flag = 1'h0;
      set_count_complete_flag = 1'h0;
      set_nack = 1'h0;
      pop = 1'h0;
      unique case (st_ff)
         i2cmt_pkg::SQ_IDLE, i2cmt_pkg::SQ_RSWAIT: begin
            if (go_start) begin
               nxt_cmd.kind = (st_ff == i2cmt_pkg::SQ_RSWAIT) ? i2cmt_pkg::CMD_RESTART :
                              i2cmt_pkg::CMD_START;
               nxt_addr = cfg_in.abd ? fifo_od : address_buffer_high_in;
               pop = cfg_in.abd;
               nxt_req = ~req_ff;
               nxt_sb = 1'h1;
               nxt_mdr = 1'h0;
               nxt_kind = i2cmt_pkg::KIND_AHI;
               nxt_st = i2cmt_pkg::SQ_START;
            end
         end
         i2cmt_pkg::SQ_START: begin
            if (done_ev) begin
               nxt_cmd = '{kind: i2cmt_pkg::CMD_BYTE, data: addr_ff};
               nxt_req = ~req_ff;
               nxt_st = i2cmt_pkg::SQ_BYTE;
            end
         end
         i2cmt_pkg::SQ_BYTE: begin
            if (mid_ev) begin
               if (need_hold) begin
                  set_tx_interrupt_flag = 1'h1;
                  nxt_mdr = 1'h1;
                  nxt_st = i2cmt_pkg::SQ_HOLD;
               end else begin
                  // count zero, word waiting or ten-bit high byte: no stretch, acknowledge is clocked at once
                  nxt_rel = ~rel_ff;
               end
            end else if (done_ev) begin
               if (nacked) begin
                  set_nack = 1'h1;
                  if (cfg_in.restart_enable & ~cfg_in.ten_bit) begin
                     nxt_mdr = 1'h1;
                     nxt_st = i2cmt_pkg::SQ_RSWAIT;
                  end else begin
                     // ten-bit addressing always stops after a refusal
                     nxt_cmd.kind = i2cmt_pkg::CMD_STOP;
                     nxt_req = ~req_ff;
                     nxt_st = i2cmt_pkg::SQ_STOP;
                  end
               end else if (ten_hi & cfg_in.abd) begin
                  set_tx_interrupt_flag = 1'h1;
                  nxt_mdr = 1'h1;
                  nxt_st = i2cmt_pkg::SQ_LOWAIT;
               end else if (ten_hi) begin
                  nxt_cmd = '{kind: i2cmt_pkg::CMD_BYTE, data: address_buffer_low_in};
                  nxt_kind = i2cmt_pkg::KIND_ALO;
                  nxt_req = ~req_ff;
               end else if (cnt_nz) begin
                  // the hold at the 8th fall guarantees a word is waiting here
                  pop = 1'h1;
                  nxt_cmd = '{kind: i2cmt_pkg::CMD_BYTE, data: fifo_od};
                  nxt_kind = i2cmt_pkg::KIND_DATA;
                  nxt_req = ~req_ff;
                  nxt_cnt = cnt_dec;
                  set_count_complete_flag = (cnt_dec == i2cmt_pkg::CNT_ZERO);
               end else if (cfg_in.restart_enable) begin
                  nxt_mdr = 1'h1;
                  nxt_st = i2cmt_pkg::SQ_RSWAIT;
               end else begin
                  nxt_cmd.kind = i2cmt_pkg::CMD_STOP;
                  nxt_req = ~req_ff;
                  nxt_st = i2cmt_pkg::SQ_STOP;
               end
            end
         end
         i2cmt_pkg::SQ_HOLD: begin
            if (fifo_ov) begin
               nxt_rel = ~rel_ff;
               nxt_mdr = 1'h0;
               nxt_st = i2cmt_pkg::SQ_BYTE;
            end
         end
         i2cmt_pkg::SQ_LOWAIT: begin
            if (fifo_ov) begin
               pop = 1'h1;
               nxt_cmd = '{kind: i2cmt_pkg::CMD_BYTE, data: fifo_od};
               nxt_kind = i2cmt_pkg::KIND_ALO;
               nxt_req = ~req_ff;
               nxt_mdr = 1'h0;
               nxt_st = i2cmt_pkg::SQ_BYTE;
            end
         end
         i2cmt_pkg::SQ_STOP: begin
            if (done_ev) begin
               nxt_sb = 1'h0;
               nxt_st = i2cmt_pkg::SQ_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_ff <= i2cmt_pkg::SQ_IDLE;
         kind_ff <= i2cmt_pkg::KIND_AHI;
         cmd_ff <= '{kind: i2cmt_pkg::CMD_STOP, data: i2cmt_pkg::CNT_ZERO};
         cnt_ff <= i2cmt_pkg::CNT_ZERO;
         addr_ff <= i2cmt_pkg::CNT_ZERO;
         {req_ff, rel_ff, mdr_ff, sb_ff, busy_ff} <= 5'h00;
         {tx_interrupt_flag_ff, count_complete_flag_ff, nack_ff} <= 3'h0;
         {ls1_ff, ls2_ff, ls3_ff, lsf_ff, lsp_ff} <= 20'h00000;
      end else begin
         st_ff <= nxt_st;
         kind_ff <= nxt_kind;
         cmd_ff <= nxt_cmd;
         // a software load beats a decrement in the same cycle
         cnt_ff <= count_load_in ? count_value_in : nxt_cnt;
         addr_ff <= nxt_addr;
         {req_ff, rel_ff, mdr_ff, sb_ff} <= {nxt_req, nxt_rel, nxt_mdr, nxt_sb};
         busy_ff <= (nxt_st != i2cmt_pkg::SQ_IDLE);
         // set wins over a clear in the same cycle
         tx_interrupt_flag_ff <= set_tx_interrupt_flag | (tx_interrupt_flag_ff & ~flag_clear_in[i2cmt_pkg::CLR_TX_INTERRUPT_FLAG]);
         count_complete_flag_ff <= set_count_complete_flag | (count_complete_flag_ff & ~flag_clear_in[i2cmt_pkg::CLR_COUNT_COMPLETE_FLAG]);
         nack_ff <= set_nack | (nack_ff & ~flag_clear_in[i2cmt_pkg::CLR_NACK]);
         ls1_ff <= l2s_raw;
         ls2_ff <= ls1_ff;
         ls3_ff <= ls2_ff;
         lsf_ff <= i2cmt_pkg::sync_filt(ls2_ff, ls3_ff, lsf_ff);
         lsp_ff <= lsf_ff;
      end
   end

   // ---------------- link domain ----------------
   logic [1:0] lrst_ff;
   wire link_rst_n = lrst_ff[1];
   logic [i2cmt_pkg::X_W-1:0] ps1_ff, ps2_ff, ps3_ff, psf_ff, psp_ff;
   i2cmt_pkg::i2cmt_eng_e est_ff, nxt_est;
   i2cmt_pkg::i2cmt_cmd_e ek_ff, nxt_ek;
   logic [1:0] ph_ff, nxt_ph;
   logic [i2cmt_pkg::QCNT_W-1:0] q_ff, nxt_q, free_cnt_ff;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh;
   logic scl_lo_ff, nxt_scl_lo, sda_lo_ff, nxt_sda_lo;
   logic nxt_mid, nxt_done, nxt_ack, pin_lvl_ff;

   wire [i2cmt_pkg::X_W-1:0] s2l_raw = {rel_ff, req_ff, sda_in, scl_in};
   wire scl_f = psf_ff[i2cmt_pkg::L_SCL];
   wire sda_f = psf_ff[i2cmt_pkg::L_SDA];
   wire req_ev = psf_ff[i2cmt_pkg::L_REQ] ^ psp_ff[i2cmt_pkg::L_REQ];
   wire rel_ev = psf_ff[i2cmt_pkg::L_REL] ^ psp_ff[i2cmt_pkg::L_REL];
   wire timed = (est_ff != i2cmt_pkg::EN_IDLE) & (est_ff != i2cmt_pkg::EN_HOLD);
   // a fresh start stands still until the bus has been idle long enough
   wire wait_free = (est_ff == i2cmt_pkg::EN_START) & (ek_ff == i2cmt_pkg::CMD_START) &
                    (ph_ff == i2cmt_pkg::PH0) & ~free_ff;
   // the high quarter only counts once scl is really high (slave stretching)
   wire counting = timed & ~wait_free & ~((ph_ff == i2cmt_pkg::PH2) & ~scl_f);
   wire tick = counting & (q_ff == i2cmt_pkg::QTR_LAST);
   wire t0 = tick & (ph_ff == i2cmt_pkg::PH0);
   wire t1 = tick & (ph_ff == i2cmt_pkg::PH1);
   wire t2 = tick & (ph_ff == i2cmt_pkg::PH2);
   wire t3 = tick & (ph_ff == i2cmt_pkg::PH3);

   assign scl_out = pin_lvl_ff;
   assign sda_out = pin_lvl_ff;
   assign scl_oe_out = scl_lo_ff;
   assign sda_oe_out = sda_lo_ff;

   always_comb begin
      nxt_est = est_ff;
      nxt_ek = ek_ff;
      nxt_ph = ph_ff;
      nxt_q = q_ff;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_scl_lo = scl_lo_ff;
      nxt_sda_lo = sda_lo_ff;
      nxt_mid = mid_tgl_ff;
      nxt_done = done_tgl_ff;
      nxt_ack = ack_ff;
      if (tick) begin
         nxt_q = i2cmt_pkg::Q_ZERO;
         nxt_ph = ph_ff + i2cmt_pkg::PH1;
      end else if (counting) begin
         nxt_q = q_ff + i2cmt_pkg::Q_ONE;
      end
      unique case (est_ff)
         i2cmt_pkg::EN_IDLE: begin
            if (req_ev) begin
               nxt_ek = cmd_ff.kind;
               nxt_sh = cmd_ff.data;
               nxt_ph = i2cmt_pkg::PH0;
               nxt_q = i2cmt_pkg::Q_ZERO;
               nxt_bit = i2cmt_pkg::BIT_FIRST;
               unique case (cmd_ff.kind)
                  i2cmt_pkg::CMD_BYTE: begin
                     nxt_est = i2cmt_pkg::EN_BIT;
                     nxt_sda_lo = ~cmd_ff.data[i2cmt_pkg::MSB];
                  end
                  i2cmt_pkg::CMD_STOP: begin
                     nxt_est = i2cmt_pkg::EN_STOP;
                     nxt_sda_lo = 1'h1;
                  end
                  default: begin
                     nxt_est = i2cmt_pkg::EN_START;
                     nxt_sda_lo = 1'h0;
                  end
               endcase
            end
         end
         i2cmt_pkg::EN_START: begin
            if (tick & (ph_ff == i2cmt_pkg::PH0)) begin
               nxt_scl_lo = 1'h0;
            end
            if (t2) begin
               nxt_sda_lo = 1'h1;
            end
            if (t3) begin
               nxt_scl_lo = 1'h1;
               nxt_done = ~done_tgl_ff;
               nxt_est = i2cmt_pkg::EN_IDLE;
            end
         end
         i2cmt_pkg::EN_BIT: begin
            if (t0) begin
               // sda moves a quarter after scl falls, never on the falling edge itself
               nxt_sda_lo = ~sh_ff[i2cmt_pkg::MSB];
            end
            if (t1) begin
               nxt_scl_lo = 1'h0;
            end
            if (t3) begin
               nxt_scl_lo = 1'h1;
               nxt_sh = {sh_ff[6:0], 1'h0};
               if (bit_ff == i2cmt_pkg::BIT_LAST) begin
                  // 8th fall: scl stays low until the sequencer lets go
                  nxt_mid = ~mid_tgl_ff;
                  nxt_est = i2cmt_pkg::EN_HOLD;
               end else begin
                  nxt_bit = bit_ff + i2cmt_pkg::BIT_ONE;
               end
            end
         end
         i2cmt_pkg::EN_HOLD: begin
            if (rel_ev) begin
               // scl is still low here, so letting sda go is not a stop
               nxt_sda_lo = 1'h0;
               nxt_est = i2cmt_pkg::EN_ACK;
               nxt_ph = i2cmt_pkg::PH0;
               nxt_q = i2cmt_pkg::Q_ZERO;
            end
         end
         i2cmt_pkg::EN_ACK: begin
            if (t1) begin
               nxt_scl_lo = 1'h0;
            end
            if (t2) begin
               nxt_ack = sda_f;
            end
            if (t3) begin
               nxt_scl_lo = 1'h1;
               nxt_done = ~done_tgl_ff;
               nxt_est = i2cmt_pkg::EN_IDLE;
            end
         end
         i2cmt_pkg::EN_STOP: begin
            if (t1) begin
               nxt_scl_lo = 1'h0;
            end
            if (t3) begin
               nxt_sda_lo = 1'h0;
               nxt_done = ~done_tgl_ff;
               nxt_est = i2cmt_pkg::EN_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lrst_ff <= 2'h0;
      end else begin
         lrst_ff <= {lrst_ff[0], 1'h1};
      end
   end

   always_ff @(posedge link_clk_in or negedge link_rst_n) begin
      if (!link_rst_n) begin
         {ps1_ff, ps2_ff, ps3_ff, psf_ff, psp_ff} <= 20'h00000;
         est_ff <= i2cmt_pkg::EN_IDLE;
         ek_ff <= i2cmt_pkg::CMD_STOP;
         ph_ff <= i2cmt_pkg::PH0;
         q_ff <= i2cmt_pkg::Q_ZERO;
         free_cnt_ff <= i2cmt_pkg::Q_ZERO;
         bit_ff <= i2cmt_pkg::BIT_FIRST;
         sh_ff <= i2cmt_pkg::CNT_ZERO;
         {scl_lo_ff, sda_lo_ff, mid_tgl_ff, done_tgl_ff} <= 4'h0;
         {ack_ff, free_ff, pin_lvl_ff} <= 3'h0;
      end else begin
         ps1_ff <= s2l_raw;
         ps2_ff <= ps1_ff;
         ps3_ff <= ps2_ff;
         psf_ff <= i2cmt_pkg::sync_filt(ps2_ff, ps3_ff, psf_ff);
         psp_ff <= psf_ff;
         est_ff <= nxt_est;
         ek_ff <= nxt_ek;
         ph_ff <= nxt_ph;
         q_ff <= nxt_q;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         {scl_lo_ff, sda_lo_ff} <= {nxt_scl_lo, nxt_sda_lo};
         {mid_tgl_ff, done_tgl_ff, ack_ff} <= {nxt_mid, nxt_done, nxt_ack};
         if (scl_f & sda_f) begin
            if (free_cnt_ff != i2cmt_pkg::FREE_FULL) begin
               free_cnt_ff <= free_cnt_ff + i2cmt_pkg::Q_ONE;
            end
         end else begin
            free_cnt_ff <= i2cmt_pkg::Q_ZERO;
         end
         free_ff <= (free_cnt_ff == i2cmt_pkg::FREE_FULL);
         pin_lvl_ff <= 1'h0;
      end
   end
endmodule // i2cmt_top
`default_nettype wire

// file: testbench/i2cmt_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module i2cmt_top_asserts (
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // watched ports
   input wire logic scl_oe_out,
   input wire logic sda_oe_out,
   input wire i2cmt_pkg::i2cmt_cfg_s cfg_in,
   input wire logic start_set_in,
   input wire logic count_load_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] byte_count_out,
   input wire i2cmt_pkg::i2cmt_stat_s status_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   chk_cnt_floor: assert property (byte_count_out == 8'h00 && !count_load_in |=>
      byte_count_out == 8'h00) else $error("count went below zero");
   chk_cnt_step: assert property (!$past(count_load_in) && $changed(byte_count_out) |->
      byte_count_out == $past(byte_count_out) - 8'h01) else $error("count step wrong");
   chk_count_complete_flag_zero: assert property ($fell(|byte_count_out) && !$past(count_load_in) |->
      ##[0:1] status_out.count_complete_flag) else $error("count_complete_flag missing");
   chk_start_go: assert property (start_set_in && !cfg_in.abd && !status_out.busy |=>
      status_out.start_bit) else $error("start not taken");
   chk_abd_skip: assert property (start_set_in && cfg_in.abd && status_out.tx_buffer_empty_flag &&
      !status_out.busy && !tx_valid_in && !$past(tx_valid_in) |=> !status_out.busy)
      else $error("start bit not ignored");
   chk_mdr_hold: assert property (status_out.master_data_request |-> scl_oe_out)
      else $error("scl not held");
   chk_idle_free: assert property (!status_out.busy |-> !scl_oe_out && !sda_oe_out)
      else $error("lines driven while idle");
   chk_nack_stop: assert property ($rose(status_out.nack) && !cfg_in.restart_enable |->
      ##[1:400] !status_out.busy) else $error("no stop after nack");
   cover property (status_out.master_data_request);
   cover property ($rose(status_out.nack));
   cover property ($rose(status_out.count_complete_flag));
endmodule // i2cmt_top_asserts
bind i2cmt_top i2cmt_top_asserts u_i2cmt_top_asserts (.mclk_in, .nrst_in, .scl_oe_out,
   .sda_oe_out, .cfg_in, .start_set_in, .count_load_in, .tx_valid_in, .byte_count_out,
   .status_out);
`default_nettype wire

// file: testbench/i2cmt_slave.sv
`timescale 1ns/1ps
`default_nettype none
module i2cmt_slave (
   // bus wires
   input wire logic scl_in,
   input wire logic sda_in,
   // answer controls
   input wire logic nack_in,
   input wire logic stretch_in,
   // pulls, high drives low
   output logic scl_oe_out,
   output logic sda_oe_out
);
   logic [7:0] sh;
   logic [7:0] log_q[$];
   int cnt = 0;
   initial scl_oe_out = 1'b0;
   initial sda_oe_out = 1'b0;
   // start or stop rearms the count; the start's own scl fall brings it to 0
   always @(sda_in) if (scl_in) cnt = -1;
   always @(posedge scl_in) sh = {sh[6:0], sda_in};
   always @(negedge scl_in) begin
      cnt = cnt + 1;
      if (cnt == 8) begin
         log_q.push_back(sh);
         sda_oe_out = !nack_in;
      end else if (cnt == 9) begin
         sda_oe_out = 1'b0;
         cnt = 0;
         // slow answer outlasts the master's low time; no edges are lost meanwhile
         if (stretch_in) begin
            scl_oe_out = 1'b1;
            #6000 scl_oe_out = 1'b0;
         end
      end
   end
endmodule // i2cmt_slave
`default_nettype wire

// file: testbench/i2cmt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2cmt_top_tb;
   logic mclk_in = 1'b0, nrst_in = 1'b0, link_clk_in = 1'b0, start_set_in = 1'b0;
   logic count_load_in = 1'b0, tx_valid_in = 1'b0, nack = 1'b0, stretch = 1'b1;
   logic [7:0] count_value_in = 8'h00, tx_data_in = 8'h00;
   logic [2:0] flag_clear = 3'h0;
   logic [7:0] address_buffer_high_in = 8'hA4, address_buffer_low_in = 8'h55;
   i2cmt_pkg::i2cmt_cfg_s cfg_in = 3'h0;
   i2cmt_pkg::i2cmt_stat_s status_out;
   wire logic scl_oe_out, sda_oe_out, s_scl_oe, s_sda_oe, tx_ready_out;
   wire logic [7:0] byte_count_out;
   wire logic scl_w = !(scl_oe_out | s_scl_oe);
   wire logic sda_w = !(sda_oe_out | s_sda_oe);
   int num_errors = 0, total_checks = 0, n;
   i2cmt_top u_i2cmt_top (.mclk_in, .nrst_in, .link_clk_in, .scl_in(scl_w), .scl_out(),
      .scl_oe_out, .sda_in(sda_w), .sda_out(), .sda_oe_out, .cfg_in, .address_buffer_high_in,
      .address_buffer_low_in, .start_set_in, .count_load_in, .count_value_in,
      .flag_clear_in(flag_clear), .tx_valid_in, .tx_data_in, .tx_ready_out, .byte_count_out,
      .status_out);
   i2cmt_slave u_i2cmt_slave (.scl_in(scl_w), .sda_in(sda_w), .nack_in(nack),
      .stretch_in(stretch), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe));
   initial forever #50 mclk_in = ~mclk_in;
   initial #3.7 forever #6 link_clk_in = ~link_clk_in;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      total_checks++;
      if (v !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge mclk_in);
      #5;
   endtask
   task automatic pulse(ref logic p);
      p = 1'b1;
      step(1);
      p = 1'b0;
      step(1);
   endtask
   task automatic wait_mdr;
      for (n = 0; n < 30000 && status_out.master_data_request !== 1'b1; n++) step(1);
   endtask
   task automatic txw(input logic [7:0] d);
      while (tx_ready_out !== 1'b1) step(1);
      tx_data_in = d;
      pulse(tx_valid_in);
   endtask
   task automatic go(input logic [7:0] c, input logic [2:0] f);
      cfg_in = f;
      count_value_in = c;
      pulse(count_load_in);
   endtask
   task automatic done(input logic [7:0] e[$]);
      step(10);
      for (n = 0; n < 30000 && status_out.busy !== 1'b0; n++) step(1);
      chk("busy", 32'h0, status_out.busy);
      chk("bytes", 32'(e.size()), 32'(u_i2cmt_slave.log_q.size()));
      foreach (e[i]) chk("byte", e[i], u_i2cmt_slave.log_q[i]);
      u_i2cmt_slave.log_q.delete();
   endtask
   task automatic t_stream;
      go(8'h08, 3'h0);
      for (int i = 0; i < 8; i++) txw(8'h11 * i[7:0]);
      step(1);
      chk("tx_ready", 32'h0, tx_ready_out);
      pulse(start_set_in);
      done('{8'hA4, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77});
      chk("count", 32'h0, byte_count_out);
      chk("count_complete_flag", 32'h1, status_out.count_complete_flag);
      chk("tx_buffer_empty_flag", 32'h1, status_out.tx_buffer_empty_flag);
      $display("stream test done");
   endtask
   task automatic t_ten;
      stretch = 1'b0;
      flag_clear = 3'h7;
      step(1);
      flag_clear = 3'h0;
      chk("count_complete_flag", 32'h0, status_out.count_complete_flag);
      go(8'h01, 3'h2);
      pulse(start_set_in);
      wait_mdr;
      chk("tx_interrupt_flag", 32'h1, status_out.tx_interrupt_flag);
      chk("scl", 32'h0, scl_w);
      txw(8'h99);
      done('{8'hA4, 8'h55, 8'h99});
      chk("count_complete_flag", 32'h1, status_out.count_complete_flag);
      $display("ten-bit test done");
   endtask
   task automatic t_restart;
      go(8'h00, 3'h1);
      pulse(start_set_in);
      wait_mdr;
      chk("scl", 32'h0, scl_w);
      cfg_in = 3'h0;
      pulse(start_set_in);
      done('{8'hA4, 8'hA4});
      chk("start", 32'h0, status_out.start_bit);
      $display("restart test done");
   endtask
   task automatic t_nack;
      nack = 1'b1;
      // count zero: a buffered word left behind would start a new transfer
      go(8'h00, 3'h4);
      pulse(start_set_in);
      step(20);
      chk("busy", 32'h0, status_out.busy);
      txw(8'h3C);
      done('{8'h3C});
      chk("nack", 32'h1, status_out.nack);
      chk("count", 32'h0, byte_count_out);
      $display("nack test done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      step(12);
      nrst_in = 1'b1;
      t_stream;
      t_ten;
      t_restart;
      t_nack;
      close_out;
   end
   initial begin
      #9000000;
      num_errors++;
      close_out;
   end
endmodule // i2cmt_top_tb
`default_nettype wire
